// File: rtl/call_unit_pkg.sv
/*
 * package for the subroutine call unit: opcode codes, field widths, cycle counts, state and carrier types.
 * assumes a 24-bit byte-addressed program space and 16-bit data stack words.
 */
package call_unit_pkg;
	localparam int unsigned PC_W          = 24;
	localparam int unsigned WORD_W        = 16;
	localparam int unsigned LOOP_W        = 8;
	localparam int unsigned COND_W        = 7;
	localparam int unsigned ACC_W         = 40;
	localparam int unsigned ACC_SEL_W     = 2;
	localparam int unsigned NUM_ACC       = 4;
	localparam int unsigned CNT_W         = 4;
	// opcode first bytes
	localparam logic [7:0]  OP_CALL_COND  = 8'h6d;
	localparam logic [7:0]  OP_CALL_ABS   = 8'h6c;
	localparam logic [7:0]  OP_CALL_ACC   = 8'h92;
	localparam logic [6:0]  OP_CALL_REL   = 7'h04;
	// instruction sizes in bytes, used for the return address
	localparam logic [PC_W-1:0] SIZE_COND = 24'h000005;
	localparam logic [PC_W-1:0] SIZE_ABS  = 24'h000004;
	localparam logic [PC_W-1:0] SIZE_REL  = 24'h000003;
	localparam logic [PC_W-1:0] SIZE_ACC  = 24'h000002;
	// total cycles per form
	localparam logic [CNT_W-1:0] CYC_COND = 4'h5;
	localparam logic [CNT_W-1:0] CYC_ABS  = 4'h5;
	localparam logic [CNT_W-1:0] CYC_REL  = 4'h6;
	localparam logic [CNT_W-1:0] CYC_ACC  = 4'ha;
	localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
	localparam logic [WORD_W-1:0] STACK_STEP = 16'h0001;
	// condition groups: [6:4] kind, [3:2] operand, [1:0] relation
	localparam logic [2:0]  CK_ACC_ZERO   = 3'h0;
	localparam logic [2:0]  CK_ACC_OVF    = 3'h1;
	localparam logic [2:0]  CK_TEST       = 3'h2;
	localparam logic [2:0]  CK_CARRY      = 3'h3;
	localparam logic [1:0]  REL_EQ        = 2'h0;
	localparam logic [1:0]  REL_NE        = 2'h1;
	localparam logic [1:0]  REL_LT        = 2'h2;
	localparam logic [1:0]  REL_GE        = 2'h3;
	localparam int unsigned ACC32_MSB     = 31;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_ADDRESS = 5'b00010,
		ST_READ    = 5'b00100,
		ST_PUSH    = 5'b01000,
		ST_DRAIN   = 5'b10000
	} call_state_e;

	typedef enum logic [1:0] {
		FORM_COND = 2'h0,
		FORM_ABS  = 2'h1,
		FORM_REL  = 2'h2,
		FORM_ACC  = 2'h3
	} call_form_e;

	typedef struct packed {
		logic            valid;
		logic [7:0]      byte0;
		logic [7:0]      byte1;
		logic [PC_W-1:0] tail;
		logic            repeat_active;
	} instr_s;

	typedef struct packed {
		logic [NUM_ACC-1:0][ACC_W-1:0] accumulator;
		logic [NUM_ACC-1:0]            accumulator_overflow_flag;
		logic [1:0]                    test_condition_flag;
		logic                          carry;
		logic                          legacy_compat_mode;
		logic                          wide_accumulator_mode;
		logic                          fast_return;
		logic [LOOP_W-1:0]             loop_context;
	} cpu_ctx_s;

	typedef struct packed {
		logic              we;
		logic [WORD_W-1:0] data_addr;
		logic [WORD_W-1:0] data_word;
		logic [WORD_W-1:0] sys_addr;
		logic [WORD_W-1:0] sys_word;
	} stack_wr_s;

	typedef struct packed {
		call_state_e                 state;
		call_form_e                  form;
		logic [CNT_W-1:0]            cnt;
		logic [PC_W-1:0]             target;
		logic [PC_W-1:0]             ret_addr;
		logic [COND_W-1:0]           cond;
		logic                        taken;
		logic [NUM_ACC-1:0][ACC_W-1:0] acc_seen;
		logic [NUM_ACC-1:0]          ovf_seen;
		logic [1:0]                  tc_seen;
		logic                        carry_seen;
		logic [WORD_W-1:0]           data_stack_pointer;
		logic [WORD_W-1:0]           system_stack_pointer;
		logic [PC_W-1:0]             program_counter;
		logic [PC_W-1:0]             return_address_reg;
		logic [LOOP_W-1:0]           control_flow_context_reg;
		stack_wr_s                   stack_wr;
		logic                        pc_load;
		logic                        ctx_clear;
		logic                        busy;
		logic                        done;
		logic                        illegal_repeat;
		logic [NUM_ACC-1:0]          ovf_clear;
	} call_regs_s;
endpackage

// File: rtl/subroutine_call_unit.sv
/*
 * subroutine call unit: decodes and sequences the conditional absolute call and the
 * accumulator, relative and absolute unconditional calls.
 * assumes instructions arrive whole from the fetch/decode front end on clk_i, status from the
 * same clock domain, and a stack memory that accepts one word on each of two stacks per write.
 */
`timescale 1ns/100ps
module subroutine_call_unit (
	input  wire logic                                clk_i,
	input  wire logic                                srst_i,
	input  wire call_unit_pkg::instr_s               instr_i,
	input  wire call_unit_pkg::cpu_ctx_s             ctx_i,
	input  wire logic                                pair_we_i,
	input  wire logic [2*call_unit_pkg::PC_W-17:0]   pair_wdata_i,
	input  wire logic [call_unit_pkg::WORD_W-1:0]    sp_init_i,
	input  wire logic [call_unit_pkg::WORD_W-1:0]    ssp_init_i,
	input  wire logic                                sp_load_i,
	output logic [2*call_unit_pkg::PC_W-17:0]        pair_rdata_o,
	output call_unit_pkg::stack_wr_s                 stack_wr_o,
	output logic [call_unit_pkg::WORD_W-1:0]         data_stack_pointer_o,
	output logic [call_unit_pkg::WORD_W-1:0]         system_stack_pointer_o,
	output logic [call_unit_pkg::PC_W-1:0]           program_counter_o,
	output logic                                     pc_load_o,
	output logic                                     ctx_clear_o,
	output logic [call_unit_pkg::NUM_ACC-1:0]        ovf_clear_o,
	output logic                                     busy_o,
	output logic                                     done_o,
	output logic                                     illegal_repeat_o
);
	import call_unit_pkg::*;

	call_regs_s r_r;
	call_regs_s r_nxt;

	// compare a value against zero with the given relation
	function automatic logic rel_zero(input logic [ACC_W-1:0] v, input logic wide, input logic [1:0] rel);
		logic z;
		logic neg;
		z   = wide ? (v == '0) : (v[ACC32_MSB:0] == '0);
		neg = wide ? v[ACC_W-1] : v[ACC32_MSB];
		case (rel)
			REL_EQ:  rel_zero = z;
			REL_NE:  rel_zero = !z;
			REL_LT:  rel_zero = neg;
			default: rel_zero = !neg;
		endcase
	endfunction

	// one condition: kind, operand index, relation
	function automatic logic eval_cond(input logic [COND_W-1:0] c, input call_regs_s s, input logic legacy,
			input logic wide);
		logic [1:0] idx;
		idx = c[3:2];
		case (c[6:4])
			CK_ACC_ZERO: eval_cond = rel_zero(s.acc_seen[idx], wide | legacy, c[1:0]);
			CK_ACC_OVF:  eval_cond = c[0] ? !s.ovf_seen[idx] : s.ovf_seen[idx];
			CK_TEST:     eval_cond = c[0] ? !s.tc_seen[idx[0]] : s.tc_seen[idx[0]];
			CK_CARRY:    eval_cond = c[0] ? !s.carry_seen : s.carry_seen;
			default:     eval_cond = 1'b0;
		endcase
	endfunction

	always_comb begin
		logic [PC_W-1:0] off_ext;
		off_ext = {{(PC_W-WORD_W){instr_i.tail[WORD_W-1]}}, instr_i.tail[WORD_W-1:0]};
		r_nxt = r_r;
		r_nxt.stack_wr.we     = 1'b0;
		r_nxt.pc_load         = 1'b0;
		r_nxt.ctx_clear       = 1'b0;
		r_nxt.done            = 1'b0;
		r_nxt.illegal_repeat  = 1'b0;
		r_nxt.ovf_clear       = '0;
		// status is sampled one cycle behind the live flags
		r_nxt.acc_seen   = ctx_i.accumulator;
		r_nxt.ovf_seen   = ctx_i.accumulator_overflow_flag;
		r_nxt.tc_seen    = ctx_i.test_condition_flag;
		r_nxt.carry_seen = ctx_i.carry;
		if (sp_load_i) begin
			r_nxt.data_stack_pointer   = sp_init_i;
			r_nxt.system_stack_pointer = ssp_init_i;
		end
		if (pair_we_i) begin
			{r_nxt.control_flow_context_reg, r_nxt.return_address_reg} = pair_wdata_i;
		end
		if (r_r.busy) begin
			r_nxt.cnt = r_r.cnt - CNT_ONE;
		end
		case (r_r.state)
			ST_IDLE: begin
				r_nxt.busy = 1'b0;
				if (instr_i.valid) begin
					r_nxt.taken = 1'b1;
					r_nxt.busy  = 1'b1;
					if (instr_i.byte0 == OP_CALL_COND) begin
						r_nxt.form     = FORM_COND;
						r_nxt.cond     = instr_i.byte1[COND_W-1:0];
						r_nxt.target   = instr_i.tail;
						r_nxt.ret_addr = r_r.program_counter + SIZE_COND;
						r_nxt.cnt      = CYC_COND - CNT_ONE;
						r_nxt.state    = ST_ADDRESS;
					end else if (instr_i.byte0 == OP_CALL_ABS) begin
						r_nxt.form     = FORM_ABS;
						r_nxt.target   = instr_i.tail;
						r_nxt.ret_addr = r_r.program_counter + SIZE_ABS;
						r_nxt.cnt      = CYC_ABS - CNT_ONE;
						r_nxt.state    = ST_ADDRESS;
					end else if (instr_i.byte0[7:1] == OP_CALL_REL) begin
						r_nxt.form     = FORM_REL;
						r_nxt.target   = r_r.program_counter + off_ext;
						r_nxt.ret_addr = r_r.program_counter + SIZE_REL;
						r_nxt.cnt      = CYC_REL - CNT_ONE;
						r_nxt.state    = ST_ADDRESS;
					end else if (instr_i.byte0 == OP_CALL_ACC) begin
						r_nxt.form     = FORM_ACC;
						r_nxt.target   = ctx_i.accumulator[instr_i.byte1[ACC_SEL_W-1:0]][PC_W-1:0];
						r_nxt.ret_addr = r_r.program_counter + SIZE_ACC;
						r_nxt.cnt      = CYC_ACC - CNT_ONE;
						r_nxt.state    = ST_ADDRESS;
					end else begin
						r_nxt.busy = 1'b0;
					end
					// repeated calls are dropped before any side effect
					if (instr_i.repeat_active && r_nxt.busy) begin
						r_nxt.busy           = 1'b0;
						r_nxt.state          = ST_IDLE;
						r_nxt.illegal_repeat = 1'b1;
					end
				end
			end
			ST_ADDRESS: begin
				if (r_r.form != FORM_COND) begin
					r_nxt.data_stack_pointer   = r_r.data_stack_pointer - STACK_STEP;
					r_nxt.system_stack_pointer = r_r.system_stack_pointer - STACK_STEP;
					r_nxt.state                = ST_PUSH;
				end else begin
					r_nxt.state = ST_READ;
				end
			end
			ST_READ: begin
				r_nxt.taken = eval_cond(r_r.cond, r_r, ctx_i.legacy_compat_mode,
					ctx_i.wide_accumulator_mode);
				if (eval_cond(r_r.cond, r_r, ctx_i.legacy_compat_mode, ctx_i.wide_accumulator_mode)) begin
					r_nxt.data_stack_pointer   = r_r.data_stack_pointer - STACK_STEP;
					r_nxt.system_stack_pointer = r_r.system_stack_pointer - STACK_STEP;
				end
				// only the overflow flag this call tested is consumed, others are left alone
				if (r_r.cond[6:4] == CK_ACC_OVF) begin
					r_nxt.ovf_clear[r_r.cond[3:2]] = r_r.ovf_seen[r_r.cond[3:2]];
				end
				r_nxt.state     = ST_PUSH;
			end
			ST_PUSH: begin
				if (r_r.taken) begin
					if (ctx_i.fast_return) begin
						r_nxt.return_address_reg       = r_r.ret_addr;
						r_nxt.control_flow_context_reg = ctx_i.loop_context;
					end else begin
						r_nxt.stack_wr.we        = 1'b1;
						r_nxt.stack_wr.data_addr = r_r.data_stack_pointer;
						r_nxt.stack_wr.data_word = r_r.ret_addr[WORD_W-1:0];
						r_nxt.stack_wr.sys_addr  = r_r.system_stack_pointer;
						r_nxt.stack_wr.sys_word  = {ctx_i.loop_context, r_r.ret_addr[PC_W-1:WORD_W]};
					end
					r_nxt.program_counter = r_r.target;
					r_nxt.pc_load         = 1'b1;
					r_nxt.ctx_clear       = 1'b1;
				end else begin
					r_nxt.program_counter = r_r.ret_addr;
					r_nxt.pc_load         = 1'b1;
				end
				r_nxt.state = ST_DRAIN;
			end
			ST_DRAIN: begin
				// pad out to the documented cycle count of the form
				if (r_r.cnt <= CNT_ONE) begin
					r_nxt.busy  = 1'b0;
					r_nxt.done  = 1'b1;
					r_nxt.state = ST_IDLE;
				end
			end
			default: begin
				r_nxt.state = ST_IDLE;
				r_nxt.busy  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r_r <= '{state: ST_IDLE, form: FORM_COND, default: '0};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign pair_rdata_o           = {r_r.control_flow_context_reg, r_r.return_address_reg};
	assign stack_wr_o             = r_r.stack_wr;
	assign data_stack_pointer_o   = r_r.data_stack_pointer;
	assign system_stack_pointer_o = r_r.system_stack_pointer;
	assign program_counter_o      = r_r.program_counter;
	assign pc_load_o              = r_r.pc_load;
	assign ctx_clear_o            = r_r.ctx_clear;
	assign ovf_clear_o            = r_r.ovf_clear;
	assign busy_o                 = r_r.busy;
	assign done_o                 = r_r.done;
	assign illegal_repeat_o       = r_r.illegal_repeat;
endmodule

// File: tb/call_unit_props.sv
/*
 * checker for the subroutine call unit: timing, refusal and stack push properties.
 * assumes it is bound to the call unit and sees only its ports.
 */
`timescale 1ns/100ps
module call_unit_props (
	input wire logic                      clk_i,
	input wire logic                      srst_i,
	input wire call_unit_pkg::instr_s     instr_i,
	input wire call_unit_pkg::cpu_ctx_s   ctx_i,
	input wire logic                      pair_we_i,
	input wire logic [31:0]               pair_wdata_i,
	input wire logic                      sp_load_i,
	input wire logic [31:0]               pair_rdata_o,
	input wire call_unit_pkg::stack_wr_s  stack_wr_o,
	input wire logic [15:0]               data_stack_pointer_o,
	input wire logic [15:0]               system_stack_pointer_o,
	input wire logic                      pc_load_o,
	input wire logic                      ctx_clear_o,
	input wire logic                      busy_o,
	input wire logic                      done_o,
	input wire logic                      illegal_repeat_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic       is_call;
	logic       take;
	logic [7:0] op;
	assign op = instr_i.byte0;
	assign is_call = op == call_unit_pkg::OP_CALL_COND || op == call_unit_pkg::OP_CALL_ABS
		|| op == call_unit_pkg::OP_CALL_ACC || op[7:1] == call_unit_pkg::OP_CALL_REL;
	assign take = instr_i.valid && !busy_o && is_call && !instr_i.repeat_active;
	cond_timing_a: assert property (take && op == call_unit_pkg::OP_CALL_COND |=> busy_o [*4] ##1 (done_o && !busy_o))
		else $error("conditional call length wrong");
	abs_timing_a: assert property (take && op == call_unit_pkg::OP_CALL_ABS |-> ##5 done_o)
		else $error("absolute call length wrong");
	rel_timing_a: assert property (take && op[7:1] == call_unit_pkg::OP_CALL_REL |-> ##6 done_o)
		else $error("relative call length wrong");
	acc_timing_a: assert property (take && op == call_unit_pkg::OP_CALL_ACC |-> ##10 done_o)
		else $error("accumulator call length wrong");
	repeat_refuse_a: assert property (instr_i.valid && !busy_o && is_call && instr_i.repeat_active
		|=> illegal_repeat_o && !busy_o && !pc_load_o) else $error("repeated call not refused");
	push_addr_a: assert property (stack_wr_o.we |-> stack_wr_o.data_addr == data_stack_pointer_o
		&& stack_wr_o.sys_addr == system_stack_pointer_o) else $error("push not at decremented pointers");
	sp_step_a: assert property (!$past(sp_load_i) && !$past(srst_i) && $changed(data_stack_pointer_o)
		|-> data_stack_pointer_o == $past(data_stack_pointer_o) - call_unit_pkg::STACK_STEP
		&& system_stack_pointer_o == $past(system_stack_pointer_o) - call_unit_pkg::STACK_STEP)
		else $error("stack pointers not stepped by one word");
	loop_word_a: assert property (stack_wr_o.we |-> stack_wr_o.sys_word[15:8] == ctx_i.loop_context)
		else $error("loop bits missing from system word");
	slow_push_a: assert property (ctx_clear_o && !ctx_i.fast_return |-> stack_wr_o.we && pc_load_o)
		else $error("slow call without push or load");
	fast_nopush_a: assert property (ctx_i.fast_return |-> !stack_wr_o.we)
		else $error("fast call wrote the stacks");
	pair_rw_a: assert property (pair_we_i |=> pair_rdata_o == $past(pair_wdata_i))
		else $error("pair register write lost");
	cover property (take && op == call_unit_pkg::OP_CALL_COND);
	cover property (stack_wr_o.we);
	cover property (illegal_repeat_o);
endmodule
bind subroutine_call_unit call_unit_props u_props (.clk_i(clk_i), .srst_i(srst_i), .instr_i(instr_i),
	.ctx_i(ctx_i), .pair_we_i(pair_we_i), .pair_wdata_i(pair_wdata_i), .sp_load_i(sp_load_i),
	.pair_rdata_o(pair_rdata_o), .stack_wr_o(stack_wr_o), .data_stack_pointer_o(data_stack_pointer_o),
	.system_stack_pointer_o(system_stack_pointer_o), .pc_load_o(pc_load_o), .ctx_clear_o(ctx_clear_o),
	.busy_o(busy_o), .done_o(done_o), .illegal_repeat_o(illegal_repeat_o));

// File: tb/stack_mem.sv
/*
 * data memory model holding the data and system stacks.
 * assumes one write strobe per push, both stacks written in the same cycle.
 */
`timescale 1ns/100ps
module stack_mem (
	input wire logic                      clk_i,
	input wire call_unit_pkg::stack_wr_s  wr_i
);
	logic [15:0] data_mem [logic [15:0]];
	logic [15:0] sys_mem  [logic [15:0]];
	int          n_writes = 0;
	// unwritten words read back unknown, so a missing push never matches
	always @(posedge clk_i) begin
		if (wr_i.we === 1'b1) begin
			data_mem[wr_i.data_addr] = wr_i.data_word;
			sys_mem[wr_i.sys_addr] = wr_i.sys_word;
			n_writes++;
		end
	end
endmodule

// File: tb/tb_subroutine_call_unit.sv
/*
 * testbench for the subroutine call unit: every call form, the test-flag, accumulator-zero and overflow conditions, legacy and fast return modes, and refusal.
 * assumes the stack memory model and the bound checker are compiled alongside.
 */
`timescale 1ns/100ps
module tb_subroutine_call_unit;
	logic                     clk_i;
	logic                     srst_i;
	call_unit_pkg::instr_s    instr_i;
	call_unit_pkg::cpu_ctx_s  ctx_i;
	logic                     pair_we_i;
	logic [31:0]              pair_wdata_i;
	logic                     sp_load_i;
	logic [31:0]              pair_rdata_o;
	call_unit_pkg::stack_wr_s stack_wr_o;
	logic [15:0]              data_stack_pointer_o;
	logic [15:0]              system_stack_pointer_o;
	logic [23:0]              program_counter_o;
	logic                     pc_load_o;
	logic                     ctx_clear_o;
	logic                     busy_o;
	logic                     done_o;
	logic                     illegal_repeat_o;
	logic [3:0]               ovf_clear_o;
	logic [3:0]               ovf_hits = '0;
	int                       num_errors = 0;
	int                       n_checks = 0;
	int                       cycles = 0;
	int                       w;
	logic [15:0]              sp_exp = 16'h0100;
	logic [15:0]              ssp_exp = 16'h0200;
	subroutine_call_unit DUT (.clk_i(clk_i), .srst_i(srst_i), .instr_i(instr_i), .ctx_i(ctx_i),
		.pair_we_i(pair_we_i), .pair_wdata_i(pair_wdata_i), .sp_init_i(16'h0100), .ssp_init_i(16'h0200),
		.sp_load_i(sp_load_i), .pair_rdata_o(pair_rdata_o), .stack_wr_o(stack_wr_o),
		.data_stack_pointer_o(data_stack_pointer_o), .system_stack_pointer_o(system_stack_pointer_o),
		.program_counter_o(program_counter_o), .pc_load_o(pc_load_o), .ctx_clear_o(ctx_clear_o),
		.ovf_clear_o(ovf_clear_o), .busy_o(busy_o), .done_o(done_o), .illegal_repeat_o(illegal_repeat_o));
	// pulse is caught mid-cycle, away from the edge that launches it
	always @(negedge clk_i) begin
		ovf_hits = ovf_hits | ovf_clear_o;
	end
	stack_mem MEM (.clk_i(clk_i), .wr_i(stack_wr_o));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			results();
		end
	end
	task automatic results();
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// returns in the done cycle, so the next call goes back to back
	task automatic call(input logic [7:0] b0, input logic [7:0] b1, input logic [23:0] tail);
		int i;
		instr_i = '{1'b1, b0, b1, tail, 1'b0};
		@(posedge clk_i);
		#1 instr_i.valid = 1'b0;
		for (i = 0; i < 20 && done_o !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk(done_o, 32'h1);
	endtask
	task automatic pushed(input logic [23:0] ret);
		sp_exp--;
		ssp_exp--;
		chk(data_stack_pointer_o, sp_exp);
		chk(system_stack_pointer_o, ssp_exp);
		chk(MEM.data_mem[sp_exp], ret[15:0]);
		chk(MEM.sys_mem[ssp_exp], {ctx_i.loop_context, ret[23:16]});
	endtask
	initial begin
		srst_i = 1'b1;
		instr_i = '0;
		ctx_i = '0;
		pair_we_i = 1'b0;
		pair_wdata_i = '0;
		sp_load_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1 srst_i = 1'b0;
		chk(program_counter_o, 32'h0);
		chk(busy_o, 32'h0);
		ctx_i.loop_context = 8'ha5;
		ctx_i.accumulator[2] = 40'hff00abcdef;
		ctx_i.accumulator[1] = 40'h0100000000;
		ctx_i.test_condition_flag = 2'h1;
		sp_load_i = 1'b1;
		pair_we_i = 1'b1;
		pair_wdata_i = 32'h5a123456;
		@(posedge clk_i);
		#1 sp_load_i = 1'b0;
		pair_we_i = 1'b0;
		chk(pair_rdata_o, 32'h5a123456);
		call(8'h6c, 8'h00, 24'h123456);
		chk(program_counter_o, 24'h123456);
		pushed(24'h000004);
		call(8'h09, 8'h00, 24'h00fffe);
		chk(program_counter_o, 24'h123454);
		pushed(24'h123459);
		call(8'h92, 8'h02, 24'h000000);
		chk(program_counter_o, 24'habcdef);
		pushed(24'h123456);
		call(8'h6d, 8'h20, 24'h000100);
		chk(program_counter_o, 24'h000100);
		pushed(24'habcdf4);
		// flag raised after the sampling edge must not turn the call
		ctx_i.test_condition_flag = 2'h0;
		w = MEM.n_writes;
		fork
			call(8'h6d, 8'h20, 24'h000200);
			begin
				repeat (2) @(posedge clk_i);
				#1 ctx_i.test_condition_flag = 2'h1;
			end
		join
		chk(program_counter_o, 24'h000105);
		chk(data_stack_pointer_o, sp_exp);
		chk(MEM.n_writes, w);
		ctx_i.legacy_compat_mode = 1'b1;
		call(8'h6d, 8'h04, 24'h000300);
		chk(program_counter_o, 24'h00010a);
		ctx_i.legacy_compat_mode = 1'b0;
		call(8'h6d, 8'h04, 24'h000200);
		chk(program_counter_o, 24'h000200);
		pushed(24'h00010f);
		ctx_i.accumulator_overflow_flag = 4'h8;
		ovf_hits = '0;
		call(8'h6d, 8'h1c, 24'h000400);
		chk(program_counter_o, 24'h000400);
		chk(ovf_hits, 32'h8);
		pushed(24'h000205);
		ctx_i.accumulator_overflow_flag = 4'h0;
		ctx_i.fast_return = 1'b1;
		w = MEM.n_writes;
		call(8'h6c, 8'h00, 24'h300000);
		chk(program_counter_o, 24'h300000);
		chk(pair_rdata_o, 32'ha5000404);
		chk(MEM.n_writes, w);
		ctx_i.fast_return = 1'b0;
		instr_i = '{1'b1, 8'h6c, 8'h00, 24'h400000, 1'b1};
		@(posedge clk_i);
		#1 instr_i.valid = 1'b0;
		chk(illegal_repeat_o, 32'h1);
		repeat (6) @(posedge clk_i);
		#1;
		chk(program_counter_o, 24'h300000);
		chk(busy_o, 32'h0);
		results();
	end
endmodule
